// ==== hibctl_pkg.sv ====
// package for the hibernation, real-time counter and tamper controller
// assumes an apb slave on pclk with 32-bit data and word-aligned registers
package hibctl_pkg;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] HIBCTL_CTRL_OFS = 8'h00;
  localparam logic [7:0] HIBCTL_RTC_OFS = 8'h04;
  localparam logic [7:0] HIBCTL_MATCH_OFS = 8'h08;
  localparam logic [7:0] HIBCTL_SUBSEC_OFS = 8'h0c;
  localparam logic [7:0] HIBCTL_SSMATCH_OFS = 8'h10;
  localparam logic [7:0] HIBCTL_TRIM_OFS = 8'h14;
  localparam logic [7:0] HIBCTL_CAL_OFS = 8'h18;
  localparam logic [7:0] HIBCTL_CALM_OFS = 8'h1c;
  localparam logic [7:0] HIBCTL_WAKE_OFS = 8'h20;
  localparam logic [7:0] HIBCTL_IEN_OFS = 8'h24;
  localparam logic [7:0] HIBCTL_RIS_OFS = 8'h28;
  localparam logic [7:0] HIBCTL_MIS_OFS = 8'h2c;
  localparam logic [7:0] HIBCTL_ICLR_OFS = 8'h30;
  localparam logic [7:0] HIBCTL_TCTL_OFS = 8'h34;
  localparam logic [7:0] HIBCTL_TSTAT_OFS = 8'h38;
  localparam logic [7:0] HIBCTL_TLOG_OFS = 8'h3c;
  localparam logic [7:0] HIBCTL_TLOGT_OFS = 8'h40;
  localparam logic [7:0] HIBCTL_MEM_OFS = 8'h80;

  // ==========================================================
  // control register fields
  localparam int HIBCTL_CTRL_EN = 0;
  localparam int HIBCTL_CTRL_RTCEN = 1;
  localparam int HIBCTL_CTRL_REQ = 2;
  localparam int HIBCTL_CTRL_BATCHK = 3;
  localparam int HIBCTL_CTRL_LBABORT = 4;
  localparam int HIBCTL_CTRL_XOSC = 5;
  localparam int HIBCTL_CTRL_MODE = 6;
  localparam int HIBCTL_CTRL_ACTIVE = 8;
  localparam int HIBCTL_CTRL_CHKBUSY = 9;

  // interrupt / wake source bit positions
  localparam int HIBCTL_EV_MATCH = 0;
  localparam int HIBCTL_EV_LOWBAT = 1;
  localparam int HIBCTL_EV_WAKEPIN = 2;
  localparam int HIBCTL_EV_GPIO = 3;
  localparam int HIBCTL_EV_RSTPIN = 4;
  localparam int HIBCTL_EV_TAMPER = 5;
  localparam int HIBCTL_NEV = 6;

  // tamper control fields
  localparam int HIBCTL_T_EN = 0;
  localparam int HIBCTL_T_ERASE_ALL = 1;
  localparam int HIBCTL_T_ERASE_HALF = 2;
  localparam int HIBCTL_T_WAKE = 3;
  localparam int HIBCTL_T_RECOVER = 4;
  localparam int HIBCTL_T_IOEN = 8;

  // ==========================================================
  // timing and reset values
  localparam int HIBCTL_TICKS_PER_SEC = 32768;
  localparam int HIBCTL_BATCHK_CYCLES = 64;
  localparam logic [15:0] HIBCTL_TRIM_RESET = 16'h7fff;
  localparam logic [7:0] HIBCTL_WILDCARD = 8'hff;

  typedef enum logic [1:0] {
    HIBCTL_MODE_RTC = 2'h0,
    HIBCTL_MODE_24H = 2'h1,
    HIBCTL_MODE_12H = 2'h2
  } hibctl_mode_t;

  typedef enum logic [3:0] {
    HIBCTL_ST_RUN = 4'b0001,
    HIBCTL_ST_HOLD = 4'b0010,
    HIBCTL_ST_SLEEP = 4'b0100,
    HIBCTL_ST_WAKE = 4'b1000
  } hibctl_state_t;

endpackage

// ==== hibctl_cal.sv ====
// calendar: seconds, minutes, hours, day, month, year in packed 6-, 5- and 4-bit fields
// assumes a one-cycle second tick from the counter in the main module
`timescale 1ns/1ps
module hibctl_cal (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic tick,
  input wire logic load,
  input wire logic [31:0] load_val,
  // state
  output logic [31:0] cal,
  output logic day_wrap
);
  import hibctl_pkg::*;

  logic [5:0] sec, min;
  logic [4:0] hr;
  logic [4:0] day;
  logic [3:0] mon;
  logic [5:0] yr;

  wire sec_end = (sec == 6'd59);
  wire min_end = sec_end && (min == 6'd59);
  wire hr_end = min_end && (hr == 5'd23);
  wire day_end = hr_end && (day == 5'd28);
  wire mon_end = day_end && (mon == 4'd12);

  assign cal = {yr, mon, day, hr, min, sec};

  // ==========================================================
  // counting; months kept at 28 days for simplicity
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sec <= '0;
      min <= '0;
      hr <= '0;
      day <= 5'd1;
      mon <= 4'd1;
      yr <= '0;
      day_wrap <= 1'b0;
    end else if (load) begin
      {yr, mon, day, hr, min, sec} <= load_val;
      day_wrap <= 1'b0;
    end else if (tick) begin
      sec <= sec_end ? 6'd0 : sec + 6'd1;
      if (sec_end) min <= (min == 6'd59) ? 6'd0 : min + 6'd1;
      if (min_end) hr <= (hr == 5'd23) ? 5'd0 : hr + 5'd1;
      if (hr_end) day <= day_end ? 5'd1 : day + 5'd1;
      if (day_end) mon <= mon_end ? 4'd1 : mon + 4'd1;
      if (mon_end) yr <= yr + 6'd1;
      day_wrap <= hr_end; // flags the day rollover second for readers
    end
  end
endmodule

// ==== hibctl_top.sv ====
// hibernation controller with real-time counter, tamper log and battery memory
// assumes an apb master on pclk; pins arrive asynchronously and are synchronised
`timescale 1ns/1ps
module hibctl_top #(
  parameter int TAMPER_INPUTS = 4,
  parameter int MEM_WORDS = 16,
  parameter int SUBSEC_TICK_DIV = 6103
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // pins
  input wire logic wake_pin,
  input wire logic gpio_wake_pin,
  input wire logic reset_pin,
  input wire logic [TAMPER_INPUTS-1:0] tamper_pin,
  input wire logic xosc_ok,
  input wire logic bat_low,
  input wire logic proc_por,
  // system control
  output logic proc_power_en,
  output logic tamper_event,
  output logic irq,
  output logic xosc_recover
);
  import hibctl_pkg::*;

  // memory index is four bits, cause log holds up to eight inputs
  if (MEM_WORDS != 16 || TAMPER_INPUTS < 1 || TAMPER_INPUTS > 8 || SUBSEC_TICK_DIV < 2) begin
    $error("hibctl_top: unsupported parameters");
  end

  // ==========================================================
  // pin synchronisers
  localparam int NP = TAMPER_INPUTS + 6;
  logic [NP-1:0] sync1, sync2, sync3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= {tamper_pin, proc_por, bat_low, xosc_ok, reset_pin, gpio_wake_pin, wake_pin};
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end
  wire s_wake = sync2[0];
  wire s_gpio = sync2[1];
  wire s_rst = sync2[2];
  wire s_xok = sync2[3];
  wire s_blow = sync2[4];
  wire por_rise = sync2[5] && !sync3[5];
  wire [TAMPER_INPUTS-1:0] t_now = sync2[NP-1:6];
  wire [TAMPER_INPUTS-1:0] t_prev = sync3[NP-1:6];

  // ==========================================================
  // registers
  logic enable, rtc_run, lb_abort, use_xosc, active_seen;
  hibctl_mode_t mode;
  logic [31:0] rtc, match, cal_match;
  logic [14:0] subsec, ss_match;
  logic [15:0] trim, sub_div;
  logic [HIBCTL_NEV-1:0] wake_sel, ien, ris;
  logic t_en, t_erase_all, t_erase_half, t_wake;
  logic [TAMPER_INPUTS-1:0] t_ioen;
  logic t_logged, xosc_failed;
  logic [7:0] t_log_cause;
  logic [31:0] t_log_time;
  logic [7:0] chk_cnt;
  logic hib_pending;
  hibctl_state_t state, next_state;
  logic [31:0] mem [MEM_WORDS];
  logic [31:0] cal;
  logic cal_wrap;

  // ==========================================================
  // apb decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire wr_ctrl = wr && (paddr == HIBCTL_CTRL_OFS);
  wire wr_rtc = wr && (paddr == HIBCTL_RTC_OFS);
  wire wr_match = wr && (paddr == HIBCTL_MATCH_OFS);
  wire wr_sub = wr && (paddr == HIBCTL_SUBSEC_OFS);
  wire wr_ssm = wr && (paddr == HIBCTL_SSMATCH_OFS);
  wire wr_trim = wr && (paddr == HIBCTL_TRIM_OFS);
  wire cal_ok = (mode != HIBCTL_MODE_RTC);
  wire wr_cal = wr && (paddr == HIBCTL_CAL_OFS) && cal_ok;
  wire wr_calm = wr && (paddr == HIBCTL_CALM_OFS) && cal_ok;
  wire wr_wake = wr && (paddr == HIBCTL_WAKE_OFS);
  wire wr_ien = wr && (paddr == HIBCTL_IEN_OFS);
  wire wr_iclr = wr && (paddr == HIBCTL_ICLR_OFS);
  wire wr_tctl = wr && (paddr == HIBCTL_TCTL_OFS);
  wire wr_tlog = wr && (paddr == HIBCTL_TLOG_OFS);
  wire mem_hit = (paddr[7:6] == HIBCTL_MEM_OFS[7:6]) && (paddr[1:0] == 2'b00);
  wire wr_mem = wr && mem_hit;
  wire [3:0] mem_idx = paddr[5:2];
  wire known = (paddr[1:0] == 2'b00) && ((paddr <= HIBCTL_TLOGT_OFS) || mem_hit);
  wire mode_bad = wr_ctrl && (pwdata[HIBCTL_CTRL_MODE+:2] == 2'h3);

  // ==========================================================
  // counter tick with trim; sub_div reload is trim-adjusted
  wire ss_tick = rtc_run && enable && (sub_div == 16'd0);
  wire sec_tick = ss_tick && (subsec == 15'h7fff);
  function automatic logic fmatch(input logic [7:0] want, input logic [7:0] have);
    fmatch = (want == HIBCTL_WILDCARD) || (want == have);
  endfunction
  wire cal_hit = fmatch(cal_match[7:0], {2'b00, cal[5:0]})
    && fmatch(cal_match[15:8], {2'b00, cal[11:6]})
    && fmatch(cal_match[23:16], {3'b000, cal[16:12]})
    && fmatch(cal_match[31:24], {3'b000, cal[21:17]});
  wire rtc_hit = cal_ok ? cal_hit : (rtc == match) && (subsec == ss_match);
  wire match_ev = ss_tick && rtc_hit;

  hibctl_cal u_cal (
    .pclk(pclk),
    .presetn(presetn),
    .tick(sec_tick && cal_ok),
    .load(wr_cal),
    .load_val(pwdata),
    .cal(cal),
    .day_wrap(cal_wrap)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sub_div <= '0;
      subsec <= '0;
      rtc <= '0;
    end else begin
      if (!rtc_run || sub_div == 16'd0)
        sub_div <= 16'(SUBSEC_TICK_DIV) + trim - HIBCTL_TRIM_RESET;
      else
        sub_div <= sub_div - 16'd1;
      if (wr_sub) subsec <= pwdata[14:0];
      else if (ss_tick) subsec <= subsec + 15'd1;
      if (wr_rtc) rtc <= pwdata;
      else if (sec_tick) rtc <= rtc + 32'd1;
    end
  end

  // ==========================================================
  // tamper detection
  wire [TAMPER_INPUTS-1:0] t_edge = (t_now ^ t_prev) & t_ioen;
  wire osc_fail = use_xosc && !s_xok && !xosc_failed;
  wire tamper_ev = t_en && ((|t_edge) || osc_fail);

  // ==========================================================
  // battery check and hibernation sequencing
  wire chk_busy = (chk_cnt != 8'd0);
  wire chk_done = (chk_cnt == 8'd1);
  wire lowbat_ev = chk_done && s_blow;
  wire [HIBCTL_NEV-1:0] ev = {tamper_ev, s_rst, s_gpio, s_wake, lowbat_ev, match_ev};
  wire wake_now = |(ev & wake_sel) || (tamper_ev && t_wake);

  always_comb begin
    next_state = state;
    case (state)
      HIBCTL_ST_RUN: if (hib_pending) next_state = HIBCTL_ST_HOLD;
      HIBCTL_ST_HOLD: begin
        if (chk_busy) next_state = HIBCTL_ST_HOLD;
        else if (lb_abort && s_blow) next_state = HIBCTL_ST_RUN;
        else next_state = HIBCTL_ST_SLEEP;
      end
      HIBCTL_ST_SLEEP: if (wake_now) next_state = HIBCTL_ST_WAKE;
      HIBCTL_ST_WAKE: next_state = HIBCTL_ST_RUN;
      default: next_state = HIBCTL_ST_RUN;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= HIBCTL_ST_RUN;
      hib_pending <= 1'b0;
      chk_cnt <= '0;
      proc_power_en <= 1'b1;
    end else begin
      state <= next_state;
      proc_power_en <= (next_state != HIBCTL_ST_SLEEP);
      if (wr_ctrl && pwdata[HIBCTL_CTRL_REQ] && enable) hib_pending <= 1'b1;
      else if (state == HIBCTL_ST_HOLD) hib_pending <= 1'b0;
      if (wr_ctrl && pwdata[HIBCTL_CTRL_BATCHK]) chk_cnt <= 8'(HIBCTL_BATCHK_CYCLES);
      else if (chk_busy) chk_cnt <= chk_cnt - 8'd1;
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      enable <= 1'b0;
      rtc_run <= 1'b0;
      lb_abort <= 1'b0;
      use_xosc <= 1'b0;
      mode <= HIBCTL_MODE_RTC;
      match <= '0;
      ss_match <= '0;
      cal_match <= '0;
      trim <= HIBCTL_TRIM_RESET;
      wake_sel <= '0;
      ien <= '0;
      t_en <= 1'b0;
      t_erase_all <= 1'b0;
      t_erase_half <= 1'b0;
      t_wake <= 1'b0;
      t_ioen <= '0;
      xosc_recover <= 1'b0;
    end else begin
      xosc_recover <= wr_tctl && pwdata[HIBCTL_T_RECOVER] && xosc_failed;
      if (wr_ctrl) begin
        enable <= pwdata[HIBCTL_CTRL_EN];
        rtc_run <= pwdata[HIBCTL_CTRL_RTCEN];
        lb_abort <= pwdata[HIBCTL_CTRL_LBABORT];
        use_xosc <= pwdata[HIBCTL_CTRL_XOSC];
        if (!mode_bad) mode <= hibctl_mode_t'(pwdata[HIBCTL_CTRL_MODE+:2]);
      end
      if (wr_match) match <= pwdata;
      if (wr_ssm) ss_match <= pwdata[14:0];
      if (wr_calm) cal_match <= pwdata;
      if (wr_trim) trim <= pwdata[15:0];
      if (wr_wake) wake_sel <= pwdata[HIBCTL_NEV-1:0];
      if (wr_ien) ien <= pwdata[HIBCTL_NEV-1:0];
      if (wr_tctl) begin
        t_en <= pwdata[HIBCTL_T_EN];
        t_erase_all <= pwdata[HIBCTL_T_ERASE_ALL];
        t_erase_half <= pwdata[HIBCTL_T_ERASE_HALF];
        t_wake <= pwdata[HIBCTL_T_WAKE];
        t_ioen <= pwdata[HIBCTL_T_IOEN+:TAMPER_INPUTS];
      end
    end
  end

  // ==========================================================
  // status flags, tamper log, active flag; set beats clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ris <= '0;
      t_logged <= 1'b0;
      t_log_cause <= '0;
      t_log_time <= '0;
      xosc_failed <= 1'b0;
      tamper_event <= 1'b0;
      irq <= 1'b0;
      active_seen <= 1'b0;
    end else begin
      ris <= (ris & ~(wr_iclr ? pwdata[HIBCTL_NEV-1:0] : '0)) | ev;
      irq <= |((ris | ev) & ien & ~(wr_iclr ? pwdata[HIBCTL_NEV-1:0] : '0));
      tamper_event <= tamper_ev;
      if (osc_fail && t_en) xosc_failed <= 1'b1;
      else if (xosc_recover && s_xok) xosc_failed <= 1'b0;
      if (tamper_ev) begin
        t_logged <= 1'b1;
        t_log_cause <= 8'({osc_fail, t_edge});
        t_log_time <= rtc;
      end else if (wr_tlog) begin
        t_logged <= 1'b0;
        t_log_cause <= '0;
      end
      if (enable) active_seen <= 1'b1;
    end
  end

  // ==========================================================
  // battery-backed memory; no reset so contents survive
  always_ff @(posedge pclk) begin
    for (int i = 0; i < MEM_WORDS; i++) begin
      if (tamper_ev && (t_erase_all || (t_erase_half && i >= MEM_WORDS / 2)))
        mem[i] <= '0;
      else if (wr_mem && mem_idx == 4'(i))
        mem[i] <= pwdata;
    end
  end

  // ==========================================================
  // read mux
  logic [31:0] rd;
  wire [31:0] ctrl_rd = {22'd0, chk_busy, active_seen, mode, use_xosc, lb_abort,
    chk_busy, 1'b0, rtc_run, enable};
  wire [31:0] tstat_rd = {29'd0, xosc_failed, t_logged, t_en};
  always_comb begin
    rd = '0;
    if (paddr == HIBCTL_CTRL_OFS) rd = ctrl_rd;
    else if (paddr == HIBCTL_RTC_OFS) rd = rtc;
    else if (paddr == HIBCTL_MATCH_OFS) rd = match;
    else if (paddr == HIBCTL_SUBSEC_OFS) rd = {17'd0, subsec};
    else if (paddr == HIBCTL_SSMATCH_OFS) rd = {17'd0, ss_match};
    else if (paddr == HIBCTL_TRIM_OFS) rd = {16'd0, trim};
    else if (paddr == HIBCTL_CAL_OFS) rd = cal_ok ? {cal_wrap, cal[30:0]} : '0;
    else if (paddr == HIBCTL_CALM_OFS) rd = cal_ok ? cal_match : '0;
    else if (paddr == HIBCTL_WAKE_OFS) rd = 32'(wake_sel);
    else if (paddr == HIBCTL_IEN_OFS) rd = 32'(ien);
    else if (paddr == HIBCTL_RIS_OFS) rd = 32'(ris);
    else if (paddr == HIBCTL_MIS_OFS) rd = 32'(ris & ien);
    else if (paddr == HIBCTL_TCTL_OFS) rd = {16'd0, 8'(t_ioen), 4'd0, t_wake, t_erase_half,
      t_erase_all, t_en};
    else if (paddr == HIBCTL_TSTAT_OFS) rd = tstat_rd;
    else if (paddr == HIBCTL_TLOG_OFS) rd = {24'd0, t_log_cause};
    else if (paddr == HIBCTL_TLOGT_OFS) rd = t_log_time;
    else if (mem_hit) rd = mem[mem_idx];
  end

  // no wait state: answer registered in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= (psel && !penable && !pwrite) ? rd : '0;
      pslverr <= psel && !penable && !known;
    end
  end
endmodule

// ==== hibctl_top_monitor.sv ====
// checker for the controller's bus answers and event outputs
// assumes it is bound to hibctl_top and sees only that module's ports
`timescale 1ns/1ps
module hibctl_top_monitor (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // system control
  input wire logic proc_power_en,
  input wire logic tamper_event,
  input wire logic xosc_recover
);
  import hibctl_pkg::*;
  default clocking mon_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========================================================
  // bus answer shape
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence answer_s;
    pready ##1 !pready;
  endsequence
  bus_answer_a: assert property (setup_s |=> answer_s)
    else $error("setup not answered by a one-cycle ready");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  idle_rdata_a: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside an answer");
  unmapped_err_a: assert property (setup_s ##0 paddr == 8'h44 |=> pslverr)
    else $error("unmapped address not refused");
  unaligned_err_a: assert property (setup_s ##0 paddr[1:0] != 2'h0 |=> pready && pslverr)
    else $error("unaligned address not refused");
  trim_ok_a: assert property (setup_s ##0 paddr == HIBCTL_TRIM_OFS |=> !pslverr)
    else $error("trim access refused");
  // ==========================================================
  // event outputs
  tamper_pulse_a: assert property (tamper_event |=> !tamper_event)
    else $error("tamper signal longer than one cycle");
  recover_pulse_a: assert property (xosc_recover |=> !xosc_recover)
    else $error("recovery pulse longer than one cycle");
  power_reset_a: assert property ($rose(presetn) |-> proc_power_en)
    else $error("processor unpowered out of reset");
endmodule

// ==== hibctl_proc_model.sv ====
// processor power domain and system control seen from the controller
// assumes the controller's power enable and event pulses on pclk
`timescale 1ns/1ps
module hibctl_proc_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // from the controller
  input wire logic proc_power_en,
  input wire logic tamper_event,
  input wire logic xosc_recover,
  // to the controller and the bench
  output logic proc_por,
  output int tamper_seen,
  output int recover_seen
);
  logic [2:0] por_cnt;
  // power-on reset stays up a few cycles after power returns
  assign proc_por = por_cnt != 3'h0;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_cnt <= 3'h0;
      tamper_seen <= 0;
      recover_seen <= 0;
    end else begin
      por_cnt <= !proc_power_en ? 3'h7 : por_cnt - 3'(por_cnt != 3'h0);
      tamper_seen <= tamper_seen + int'(tamper_event);
      recover_seen <= recover_seen + int'(xosc_recover);
    end
  end
endmodule

// ==== hibctl_tb_top.sv ====
// bench for the hibernation controller: apb tasks and directed tests
// assumes the processor model file and the checker are compiled before it
`timescale 1ns/1ps
module hibctl_tb_top;
  import hibctl_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, a, b;
  logic wake_pin, gpio_wake_pin, reset_pin, xosc_ok, bat_low, proc_por;
  logic [3:0] tamper_pin;
  logic proc_power_en, tamper_event, irq, xosc_recover;
  int err_total, checked, cycles, tamper_seen, recover_seen;
  logic [7:0] ofs [6] = '{HIBCTL_RTC_OFS, HIBCTL_MATCH_OFS, HIBCTL_SSMATCH_OFS,
    HIBCTL_TRIM_OFS, HIBCTL_WAKE_OFS, HIBCTL_IEN_OFS};
  logic [31:0] msk [6] = '{32'hffffffff, 32'hffffffff, 32'h7fff, 32'hffff, 32'h3f, 32'h3f};
  // short subsecond divider keeps the run brief
  hibctl_top #(.TAMPER_INPUTS(4), .MEM_WORDS(16), .SUBSEC_TICK_DIV(2)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .wake_pin(wake_pin), .gpio_wake_pin(gpio_wake_pin), .reset_pin(reset_pin),
    .tamper_pin(tamper_pin), .xosc_ok(xosc_ok), .bat_low(bat_low), .proc_por(proc_por),
    .proc_power_en(proc_power_en), .tamper_event(tamper_event), .irq(irq),
    .xosc_recover(xosc_recover));
  hibctl_proc_model proc (.pclk(pclk), .presetn(presetn), .proc_power_en(proc_power_en),
    .tamper_event(tamper_event), .xosc_recover(xosc_recover), .proc_por(proc_por),
    .tamper_seen(tamper_seen), .recover_seen(recover_seen));
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // ==========================================================
  // checking and bus tasks
  task end_of_test();
    $display("checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask
  // request stands until the edge that samples ready high; only the timeout ends a wait
  task apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= ad;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [7:0] ad, input logic [31:0] d);
    apb(1'b1, ad, d);
  endtask
  task rdc(input logic [7:0] ad, input logic [31:0] exp, input string what);
    apb(1'b0, ad, 32'h0);
    chk(rd, exp, what);
  endtask
  task wait_pwr(input logic lvl, input string what);
    int n;
    n = 0;
    while (proc_power_en !== lvl && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    chk({31'h0, proc_power_en}, {31'h0, lvl}, what);
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      err_total++;
      end_of_test();
    end
  end
  // ==========================================================
  // tests
  initial begin
    {psel, penable, pwrite, wake_pin, gpio_wake_pin, reset_pin, bat_low} = 7'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    tamper_pin = 4'h0;
    xosc_ok = 1'b1;
    presetn = 1'b0;
    {err_total, checked, cycles} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdc(HIBCTL_TRIM_OFS, {16'h0, HIBCTL_TRIM_RESET}, "trim reset");
    wr(HIBCTL_CTRL_OFS, 32'h1);
    for (int i = 0; i < 6; i++) begin
      wr(ofs[i], 32'ha5c35a3c);
      rdc(ofs[i], 32'ha5c35a3c & msk[i], "readback");
    end
    // nominal trim again, else the subsecond period grows to tens of thousands of cycles
    wr(HIBCTL_TRIM_OFS, {16'h0, HIBCTL_TRIM_RESET});
    for (int i = 0; i < 16; i++) wr(HIBCTL_MEM_OFS + 8'(4 * i), 32'h1000 + i);
    for (int i = 0; i < 16; i++) rdc(HIBCTL_MEM_OFS + 8'(4 * i), 32'h1000 + i, "mem");
    rdc(8'h44, 32'h0, "unmapped read");
    chk({31'h0, er}, 32'h1, "unmapped error");
    apb(1'b1, 8'h06, 32'h0);
    chk({31'h0, er}, 32'h1, "unaligned error");
    $display("test registers done");
    wr(HIBCTL_CTRL_OFS, 32'h3);
    apb(1'b0, HIBCTL_SUBSEC_OFS, 32'h0);
    a = rd;
    repeat (40) @(posedge pclk);
    apb(1'b0, HIBCTL_SUBSEC_OFS, 32'h0);
    chk({31'h0, a !== rd}, 32'h1, "subsec runs");
    chk(rd & 32'hffff8000, 32'h0, "subsec width");
    wr(HIBCTL_CTRL_OFS, 32'h1);
    apb(1'b0, HIBCTL_SUBSEC_OFS, 32'h0);
    a = rd;
    repeat (40) @(posedge pclk);
    rdc(HIBCTL_SUBSEC_OFS, a, "subsec stopped");
    wr(HIBCTL_RTC_OFS, 32'h1234);
    $display("test counter done");
    b = {1'b0, 5'd1, 4'd1, 5'd1, 5'd2, 6'd3, 6'd5};
    wr(HIBCTL_CTRL_OFS, 32'h41);
    wr(HIBCTL_CAL_OFS, b);
    apb(1'b0, HIBCTL_CAL_OFS, 32'h0);
    if (rd[31]) begin
      repeat (HIBCTL_TICKS_PER_SEC * 2) @(posedge pclk);
      apb(1'b0, HIBCTL_CAL_OFS, 32'h0);
    end
    chk(rd, b, "calendar");
    wr(HIBCTL_CALM_OFS, 32'hff020305);
    rdc(HIBCTL_CALM_OFS, 32'hff020305, "calendar match");
    wr(HIBCTL_ICLR_OFS, 32'h3f);
    wr(HIBCTL_CTRL_OFS, 32'h43);
    repeat (10) @(posedge pclk);
    wr(HIBCTL_CTRL_OFS, 32'h41);
    rdc(HIBCTL_RIS_OFS, 32'h1, "wildcard match");
    wr(HIBCTL_CTRL_OFS, 32'hc1);
    apb(1'b0, HIBCTL_CTRL_OFS, 32'h0);
    chk({30'h0, rd[7:6]}, 32'h1, "mode code 3");
    wr(HIBCTL_CTRL_OFS, 32'h1);
    rdc(HIBCTL_CAL_OFS, 32'h0, "calendar gated");
    $display("test calendar done");
    wr(HIBCTL_IEN_OFS, 32'h0);
    wr(HIBCTL_ICLR_OFS, 32'h3f);
    for (int i = 0; i < 3; i++) begin
      wr(HIBCTL_WAKE_OFS, 32'h4 << i);
      if (i == 0) begin
        wr(HIBCTL_CTRL_OFS, 32'h9);
        wr(HIBCTL_CTRL_OFS, 32'h5);
        repeat (10) @(posedge pclk);
        chk({31'h0, proc_power_en}, 32'h1, "held by check");
        apb(1'b0, HIBCTL_CTRL_OFS, 32'h0);
        chk({31'h0, rd[9]}, 32'h1, "check busy");
      end else wr(HIBCTL_CTRL_OFS, 32'h5);
      wait_pwr(1'b0, "sleep");
      {reset_pin, gpio_wake_pin, wake_pin} <= 3'h1 << i;
      repeat (10) @(posedge pclk);
      {reset_pin, gpio_wake_pin, wake_pin} <= 3'h0;
      wait_pwr(1'b1, "wake");
      repeat (10) @(posedge pclk);
      apb(1'b0, HIBCTL_CTRL_OFS, 32'h0);
      chk({31'h0, rd[8]}, 32'h1, "active");
      apb(1'b0, HIBCTL_RIS_OFS, 32'h0);
      chk({31'h0, rd[2 + i]}, 32'h1, "wake cause");
      wr(HIBCTL_ICLR_OFS, 32'h3f);
      apb(1'b0, HIBCTL_RIS_OFS, 32'h0);
      chk({31'h0, rd[2 + i]}, 32'h0, "cause cleared");
    end
    rdc(HIBCTL_MEM_OFS, 32'h1000, "mem kept");
    $display("test hibernate done");
    wr(HIBCTL_IEN_OFS, 32'h2);
    bat_low <= 1'b1;
    wr(HIBCTL_CTRL_OFS, 32'h19);
    for (int n = 0; n < 100; n++) begin
      apb(1'b0, HIBCTL_CTRL_OFS, 32'h0);
      if (!rd[9]) break;
    end
    chk({31'h0, rd[9]}, 32'h0, "check ends");
    rdc(HIBCTL_MIS_OFS, 32'h2, "low flag");
    chk({31'h0, irq}, 32'h1, "irq");
    wr(HIBCTL_CTRL_OFS, 32'h15);
    repeat (200) @(posedge pclk);
    chk({31'h0, proc_power_en}, 32'h1, "abort on low");
    wr(HIBCTL_ICLR_OFS, 32'h2);
    rdc(HIBCTL_MIS_OFS, 32'h0, "low cleared");
    chk({31'h0, irq}, 32'h0, "irq off");
    bat_low <= 1'b0;
    $display("test battery done");
    wr(HIBCTL_MEM_OFS + 8'hc, 32'hbeef);
    wr(HIBCTL_TCTL_OFS, 32'h103);
    tamper_pin[0] <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(tamper_seen, 32'h1, "tamper signal");
    rdc(HIBCTL_TSTAT_OFS, 32'h3, "tamper status");
    rdc(HIBCTL_TLOG_OFS, 32'h1, "log cause");
    rdc(HIBCTL_TLOGT_OFS, 32'h1234, "log time");
    rdc(HIBCTL_MEM_OFS + 8'hc, 32'h0, "erased");
    wr(HIBCTL_TLOG_OFS, 32'h0);
    rdc(HIBCTL_TLOG_OFS, 32'h0, "log cleared");
    wr(HIBCTL_TCTL_OFS, 32'h200);
    tamper_pin[1] <= 1'b1;
    repeat (10) @(posedge pclk);
    chk(tamper_seen, 32'h1, "master off");
    wr(HIBCTL_CTRL_OFS, 32'h21);
    wr(HIBCTL_TCTL_OFS, 32'h1);
    xosc_ok <= 1'b0;
    repeat (10) @(posedge pclk);
    chk(tamper_seen, 32'h2, "osc tamper");
    apb(1'b0, HIBCTL_TSTAT_OFS, 32'h0);
    chk({31'h0, rd[2]}, 32'h1, "osc failed");
    xosc_ok <= 1'b1;
    wr(HIBCTL_TCTL_OFS, 32'h11);
    repeat (4) @(posedge pclk);
    chk(recover_seen, 32'h1, "recover");
    $display("test tamper done");
    end_of_test();
  end
endmodule
bind hibctl_top hibctl_top_monitor mon (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .proc_power_en(proc_power_en), .tamper_event(tamper_event), .xosc_recover(xosc_recover));
